//--- aes_pkg.sv
package aes_pkg;
	// Shared protocol codes for input_protocol_sel
	localparam logic [1:0]  PROT_00       = 2'h0;
	localparam logic [1:0]  PROT_01       = 2'h1;
	localparam logic [1:0]  PROT_10       = 2'h2;
	localparam logic [1:0]  PROT_11       = 2'h3;
	localparam logic [1:0]  OUT_SEL_SPI   = 2'h0;
	localparam logic [4:0]  CMD_WR        = 5'h01;
	localparam logic [4:0]  CMD_RD        = 5'h02;
	localparam logic [10:0] ADDR_IN_CTRL  = 11'h008;
	localparam logic [10:0] ADDR_OUT_CTRL = 11'h00C;
	localparam logic [7:0]  IN_CTRL_RST   = 8'h00;
	localparam logic [7:0]  OUT_CTRL_RST  = 8'h00;
	localparam int          LANE_BIT_POS  = 2;
	localparam logic [4:0]  REG_FRAME_BITS  = 5'h18;
	localparam logic [4:0]  CONV_FRAME_BITS = 5'h10;
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          SCLK_HALF_NS  = 1200;
	localparam int          SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
	localparam int          FIFO_DEPTH    = 4;
	localparam int          CONV_WIDTH    = 16;
endpackage

//--- aes_link_if.sv
interface aes_link_if;
	logic cs_n;     // Chip select, low in frame
	logic sclk;     // Serial clock from host
	logic serial_data_in;      // serial_data_in
	logic sdo0;     // data_out_lane0
	logic sdo1;     // data_out_lane1 / sequence_status_pin
	logic sdo1_oe;  // Device drives lane 1
	logic ready;    // Ready or re-timed clock

	modport dev (
		input  cs_n, sclk, serial_data_in,
		output sdo0, sdo1, sdo1_oe, ready
	);
	modport hst (
		output cs_n, sclk, serial_data_in,
		input  sdo0, sdo1, sdo1_oe, ready
	);
endinterface

//--- aes_fifo.sv
module aes_fifo #(
	parameter int W = 16,
	parameter int D = 4
) (
	input  wire logic         i_clk,     // Clock
	input  wire logic         i_rst_n,   // Async reset, low
	input  wire logic         i_valid,   // Write valid
	output logic              o_ready,   // Not full
	input  wire logic [W-1:0] i_data,    // Write data
	output logic              o_valid,   // Not empty
	input  wire logic         i_ready,   // Read accept
	output logic [W-1:0]      o_data     // Head word
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	generate
		if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
			$error("aes_fifo depth must be a power of two >= 2");
		end
	endgenerate

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   n_q, n_d;
	logic          push, pop;

	assign o_ready = (n_q != (AW+1)'(D));
	assign o_valid = (n_q != '0);
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;
	assign o_data  = mem[rp_q];

	always_comb begin
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		n_d  = n_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			n_q  <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			n_q  <= n_d;
		end
	end

	// Storage needs no reset; empty flag guards it
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wp_q] <= i_data;
		end
	end
endmodule // aes_fifo

//--- aes_dev.sv
// Contract
// RL1: Four clock protocols, codes 00h to 03h
// RL2: MSB launch point depends on protocol code
// RL3: Reset selects polarity-low, rising-capture protocol
// RL4: Host changes protocol using default first
// RL5: One protocol setting for reads and writes
// RL6: Register access needs 24 clocks per frame
// RL7: Conversion read needs at least 16 clocks
// RL8: Ready held low through SPI frames
// RL9: Lane-width bit enables second output lane
// RL10: Dual lane drives two bits per edge
// RL11: Re-timer mode outputs clock on ready
// RL12: Re-timer mode honours the lane-width bit
// RL13: Dual lane keeps same per-edge timing
// RL14: Write frame decoded at chip-select rise
// RL15: Read returns register in next frame
// RL16: Output words shift most significant first
module aes_dev #(
	parameter int DEPTH = aes_pkg::FIFO_DEPTH
) (
	input  wire logic        i_clk,        // 10 MHz clock
	input  wire logic        i_rst_n,      // Async reset, low
	aes_link_if.dev          link,         // Serial pins
	input  wire logic        i_conv_valid, // Conversion word valid
	output logic             o_conv_ready, // FIFO can take word
	input  wire logic [15:0] i_conv_data,  // Conversion word
	output logic             o_wr_valid,   // Other-register write
	output logic [10:0]      o_wr_addr,    // Write address
	output logic [7:0]       o_wr_data,    // Write data
	output logic [10:0]      o_rd_addr,    // Pending read address
	input  wire logic [7:0]  i_rd_data     // Other-register data
);
	// Pin synchroniser: {cs_n, sclk, sdi}
	logic [2:0] s1_q, s2_q, s3_q, f_q, f_d;
	logic [1:0] prev_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			// Idle pin levels, so no false edge follows reset
			s1_q   <= 3'h4;
			s2_q   <= 3'h4;
			s3_q   <= 3'h4;
			f_q    <= 3'h4;
			prev_q <= 2'h2;
		end else begin
			s1_q   <= {link.cs_n, link.sclk, link.serial_data_in};
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			f_q    <= f_d;
			prev_q <= f_q[2:1];
		end
	end

	// A change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_filt
			always_comb begin
				f_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : f_q[g];
			end
		end
	endgenerate

	logic f_cs_n, f_sclk, f_sdi;
	logic cs_fall, cs_rise, sck_rise, sck_fall;
	assign f_cs_n   = f_q[2];
	assign f_sclk   = f_q[1];
	assign f_sdi    = f_q[0];
	assign cs_fall  = prev_q[1] & ~f_cs_n;
	assign cs_rise  = ~prev_q[1] & f_cs_n;
	assign sck_rise = ~f_cs_n & ~prev_q[0] & f_sclk;
	assign sck_fall = ~f_cs_n & prev_q[0] & ~f_sclk;

	logic [1:0]  prot_q, prot_d;
	logic [7:0]  octl_q, octl_d;
	logic [23:0] rx_q, rx_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [15:0] tx_q, tx_d;
	logic        sdo0_q, sdo0_d, sdo1_q, sdo1_d;
	logic        rdp_q, rdp_d, rdy_q, rdy_d;
	logic [10:0] rda_q, rda_d;
	logic        wrv_q, wrv_d;
	logic [10:0] wra_q, wra_d;
	logic [7:0]  wrd_q, wrd_d;

	logic        cpha, cap_rise, cap_edge, launch_edge, dual, retime;
	logic        fifo_valid, fifo_pop;
	logic [15:0] fifo_data;
	logic [7:0]  reg_rdata;

	// Single protocol field serves both directions
	assign cpha     = prot_q[0];                              // [RL1] [RL5]
	assign cap_rise = (prot_q == aes_pkg::PROT_00)
	                | (prot_q == aes_pkg::PROT_11);           // [RL1]
	assign cap_edge    = cap_rise ? sck_rise : sck_fall;
	assign launch_edge = cap_rise ? sck_fall : sck_rise;
	assign dual   = octl_q[aes_pkg::LANE_BIT_POS];            // [RL9] [RL12]
	assign retime = (octl_q[1:0] != aes_pkg::OUT_SEL_SPI);

	always_comb begin
		unique case (rda_q)
			aes_pkg::ADDR_IN_CTRL:  reg_rdata = {6'h00, prot_q};
			aes_pkg::ADDR_OUT_CTRL: reg_rdata = octl_q;
			default:                reg_rdata = i_rd_data;
		endcase
	end

	always_comb begin
		logic [15:0] w;
		w        = 16'h0000;
		prot_d   = prot_q;
		octl_d   = octl_q;
		rx_d     = rx_q;
		cnt_d    = cnt_q;
		tx_d     = tx_q;
		sdo0_d   = sdo0_q;
		sdo1_d   = sdo1_q;
		rdp_d    = rdp_q;
		rda_d    = rda_q;
		rdy_d    = rdy_q;
		wrv_d    = 1'b0;
		wra_d    = wra_q;
		wrd_d    = wrd_q;
		fifo_pop = 1'b0;
		if (cs_fall) begin
			cnt_d = 5'h00;
			if (rdp_q) begin
				w     = {reg_rdata, 8'h00};                   // [RL15]
				rdp_d = 1'b0;
			end else if (fifo_valid) begin
				w        = fifo_data;
				fifo_pop = 1'b1;
			end
			tx_d   = w;
			sdo0_d = 1'b0;
			sdo1_d = 1'b0;
			// Phase 0 puts MSB out at select fall
			if (!cpha) begin                                  // [RL2]
				if (dual) begin                               // [RL10]
					sdo1_d = w[15];
					sdo0_d = w[14];
					tx_d   = {w[13:0], 2'h0};
				end else begin
					sdo0_d = w[15];
					tx_d   = {w[14:0], 1'b0};                 // [RL16]
				end
			end
		end else if (launch_edge) begin
			// Same edge timing for one or two lanes
			if (dual) begin                                   // [RL10] [RL13]
				sdo1_d = tx_q[15];
				sdo0_d = tx_q[14];
				tx_d   = {tx_q[13:0], 2'h0};
			end else begin
				sdo0_d = tx_q[15];
				tx_d   = {tx_q[14:0], 1'b0};                  // [RL16]
			end
		end
		if (cap_edge) begin
			rx_d = {rx_q[22:0], f_sdi};
			if (cnt_q != 5'h1F) begin
				cnt_d = cnt_q + 5'h01;
			end
		end
		// Short frames are dropped, never half-decoded
		if (cs_rise && cnt_q == aes_pkg::REG_FRAME_BITS) begin   // [RL6]
			if (rx_q[23:19] == aes_pkg::CMD_WR) begin          // [RL14]
				unique case (rx_q[18:8])
					aes_pkg::ADDR_IN_CTRL:  prot_d = rx_q[1:0];
					aes_pkg::ADDR_OUT_CTRL: octl_d = rx_q[7:0];
					default: begin
						wrv_d = 1'b1;
						wra_d = rx_q[18:8];
						wrd_d = rx_q[7:0];
					end
				endcase
			end else if (rx_q[23:19] == aes_pkg::CMD_RD) begin // [RL15]
				rdp_d = 1'b1;
				rda_d = rx_q[18:8];
			end
		end
		// Ready: in SPI mode data flag between frames, low inside; in re-timer mode low between frames, clock inside
		if (!f_cs_n) begin
			if (!retime) begin
				rdy_d = 1'b0;                                 // [RL8]
			end else begin
				// Tracks the clock that data is launched on
				rdy_d = f_sclk;                               // [RL11]
			end
		end else begin
			rdy_d = retime ? 1'b0 : fifo_valid;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prot_q <= aes_pkg::PROT_00;                       // [RL3]
			octl_q <= aes_pkg::OUT_CTRL_RST;
			rx_q   <= 24'h000000;
			cnt_q  <= 5'h00;
			tx_q   <= 16'h0000;
			sdo0_q <= 1'b0;
			sdo1_q <= 1'b0;
			rdp_q  <= 1'b0;
			rda_q  <= 11'h000;
			rdy_q  <= 1'b0;
			wrv_q  <= 1'b0;
			wra_q  <= 11'h000;
			wrd_q  <= 8'h00;
		end else begin
			prot_q <= prot_d;
			octl_q <= octl_d;
			rx_q   <= rx_d;
			cnt_q  <= cnt_d;
			tx_q   <= tx_d;
			sdo0_q <= sdo0_d;
			sdo1_q <= sdo1_d;
			rdp_q  <= rdp_d;
			rda_q  <= rda_d;
			rdy_q  <= rdy_d;
			wrv_q  <= wrv_d;
			wra_q  <= wra_d;
			wrd_q  <= wrd_d;
		end
	end

	aes_fifo #(
		.W (16),
		.D (DEPTH)
	) i_aes_fifo (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_valid (i_conv_valid),
		.o_ready (o_conv_ready),
		.i_data  (i_conv_data),
		.o_valid (fifo_valid),
		.i_ready (fifo_pop),
		.o_data  (fifo_data)
	);

	assign link.sdo0    = sdo0_q;
	assign link.sdo1    = sdo1_q;
	assign link.sdo1_oe = dual;                               // [RL9]
	assign link.ready   = rdy_q;
	assign o_wr_valid   = wrv_q;
	assign o_wr_addr    = wra_q;
	assign o_wr_data    = wrd_q;
	assign o_rd_addr    = rda_q;
endmodule // aes_dev

//--- aes_host.sv
module aes_host #(
	parameter int HALF = aes_pkg::SCLK_HALF_CYC
) (
	input  wire logic        i_clk,   // 10 MHz clock
	input  wire logic        i_rst_n, // Async reset, low
	aes_link_if.hst          link,    // Serial pins
	input  wire logic        i_start, // Start frame, pulse
	input  wire logic [23:0] i_word,  // Word to send, MSB first
	input  wire logic [4:0]  i_nbits, // Clocks in frame
	output logic             o_busy,  // Frame in progress
	output logic             o_done,  // Frame end, pulse
	output logic [23:0]      o_rx     // Received bits
);
	generate
		if (HALF < 10 || HALF > 65536) begin : g_chk
			$error("aes_host HALF must lie in 10 to 65536");
		end
	endgenerate

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_RUN  = 2'b10,
		ST_TAIL = 2'b11
	} aes_hst_e;

	logic [1:0] s1_q, s2_q, s3_q, f_q, f_d;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			f_q  <= 2'h0;
		end else begin
			s1_q <= {link.sdo1, link.sdo0};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= f_d;
		end
	end
	always_comb begin
		f_d = (s2_q == s3_q) ? s3_q : f_q;
	end

	aes_hst_e    st_q, st_d;
	logic [15:0] div_q, div_d;
	logic [5:0]  edg_q, edg_d;
	logic        sclk_q, sclk_d, cs_q, cs_d, sdi_q, sdi_d, done_q, done_d;
	logic [23:0] tx_q, tx_d, rx_q, rx_d, wd_q, wd_d;
	logic [4:0]  nb_q, nb_d;
	logic [1:0]  prot_q, prot_d;
	logic        lane_q, lane_d, tick;

	assign tick = (div_q == 16'(HALF - 1));

	always_comb begin
		st_d   = st_q;
		div_d  = tick ? 16'h0000 : div_q + 16'h0001;
		edg_d  = edg_q;
		sclk_d = sclk_q;
		cs_d   = cs_q;
		sdi_d  = sdi_q;
		done_d = 1'b0;
		tx_d   = tx_q;
		rx_d   = rx_q;
		wd_d   = wd_q;
		nb_d   = nb_q;
		prot_d = prot_q;
		lane_d = lane_q;
		unique case (st_q)
			ST_IDLE: begin
				div_d  = 16'h0000;
				sclk_d = prot_q[1];                           // [RL1]
				if (i_start) begin
					st_d  = ST_LEAD;
					cs_d  = 1'b0;
					edg_d = 6'h00;
					wd_d  = i_word;
					nb_d  = i_nbits;                          // [RL6] [RL7]
					tx_d  = i_word;
					sdi_d = 1'b0;
					if (!prot_q[0]) begin
						sdi_d = i_word[23];
						tx_d  = {i_word[22:0], 1'b0};
					end
				end
			end
			ST_LEAD: begin
				if (tick) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (tick) begin
					sclk_d = ~sclk_q;
					edg_d  = edg_q + 6'h01;
					if (edg_q[0] == prot_q[0]) begin
						rx_d = lane_q ? {rx_q[21:0], f_q}
						              : {rx_q[22:0], f_q[0]};
					end else begin
						sdi_d = tx_q[23];
						tx_d  = {tx_q[22:0], 1'b0};
					end
					if (edg_q == {nb_q, 1'b0} - 6'h01) begin
						st_d = ST_TAIL;
					end
				end
			end
			ST_TAIL: begin
				if (tick) begin
					st_d   = ST_IDLE;
					cs_d   = 1'b1;
					done_d = 1'b1;
					// New setting applies from next frame only
					if (nb_q == aes_pkg::REG_FRAME_BITS
					    && wd_q[23:19] == aes_pkg::CMD_WR) begin // [RL4]
						if (wd_q[18:8] == aes_pkg::ADDR_IN_CTRL) begin
							prot_d = wd_q[1:0];
						end
						if (wd_q[18:8] == aes_pkg::ADDR_OUT_CTRL) begin
							lane_d = wd_q[aes_pkg::LANE_BIT_POS];
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q   <= ST_IDLE;
			div_q  <= 16'h0000;
			edg_q  <= 6'h00;
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
			sdi_q  <= 1'b0;
			done_q <= 1'b0;
			tx_q   <= 24'h000000;
			rx_q   <= 24'h000000;
			wd_q   <= 24'h000000;
			nb_q   <= 5'h00;
			prot_q <= aes_pkg::PROT_00;                       // [RL3]
			lane_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			div_q  <= div_d;
			edg_q  <= edg_d;
			sclk_q <= sclk_d;
			cs_q   <= cs_d;
			sdi_q  <= sdi_d;
			done_q <= done_d;
			tx_q   <= tx_d;
			rx_q   <= rx_d;
			wd_q   <= wd_d;
			nb_q   <= nb_d;
			prot_q <= prot_d;
			lane_q <= lane_d;
		end
	end

	assign link.cs_n = cs_q;
	assign link.sclk = sclk_q;
	assign link.serial_data_in  = sdi_q;
	assign o_busy    = (st_q != ST_IDLE);
	assign o_done    = done_q;
	assign o_rx      = rx_q;
endmodule // aes_host

//--- aes_props.sv
module aes_props (
	input wire logic i_clk,   // Clock
	input wire logic i_rst_n, // Async reset, low
	input wire logic cs_n,    // Chip select
	input wire logic sclk,    // Serial clock
	input wire logic sdo0,    // Lane 0
	input wire logic sdo1,    // Lane 1
	input wire logic sdo1_oe, // Lane 1 enable
	input wire logic ready    // Ready or clock
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       sclk_q;
	logic       cs_q;
	logic [5:0] edges_q;
	logic [5:0] edges_d;
	logic [3:0] quiet_q;
	logic [3:0] quiet_d;
	logic [9:0] len_q;
	logic [9:0] len_d;

	// Quiet counts cycles since the last sclk or cs_n change at the pins
	always_comb begin
		edges_d = cs_n ? 6'h00 : edges_q + 6'(sclk != sclk_q);
		quiet_d = (sclk != sclk_q || cs_n != cs_q) ? 4'h0
			: quiet_q + 4'(quiet_q != 4'hF);
		len_d = cs_n ? 10'h000 : len_q + 10'h001;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			edges_q <= 6'h00;
			quiet_q <= 4'h0;
			len_q <= 10'h000;
		end else begin
			sclk_q <= sclk;
			cs_q <= cs_n;
			edges_q <= edges_d;
			quiet_q <= quiet_d;
			len_q <= len_d;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	frame_edges_a: assert property (
		$rose(cs_n) |-> edges_q == 6'h20 || edges_q == 6'h30)
		else $error("serial clock edge count in frame wrong");
	setup_sclk_a: assert property (
		$fell(cs_n) |-> $stable(sclk) [*8])
		else $error("serial clock moved right after frame start");
	ready_low_a: assert property (
		$fell(cs_n) |-> ##6 !ready [*4])
		else $error("ready not low in frame");
	lane_stable_a: assert property (
		!cs_n && !$past(cs_n) |-> $stable(sdo1_oe))
		else $error("lane width changed inside a frame");
	lane_reset_a: assert property (
		$rose(i_rst_n) |-> !sdo1_oe && cs_n)
		else $error("lane 1 enabled after reset");
	launch0_a: assert property (
		!cs_n && $changed(sdo0) |-> quiet_q < 4'hA)
		else $error("lane 0 changed away from a launch");
	launch1_a: assert property (
		!cs_n && $changed(sdo1) |-> quiet_q < 4'hA)
		else $error("lane 1 changed away from a launch");
	frame_len_a: assert property (
		!cs_n |-> len_q < 10'h320)
		else $error("frame too long");
endmodule // aes_props

//--- aes_tb_top.sv
module aes_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        i_clk;
	logic        i_rst_n;
	logic        start;
	logic        busy;
	logic        done;
	logic [23:0] word;
	logic [23:0] rx;
	logic [4:0]  nbits;
	logic        cv;
	logic        cr;
	logic [15:0] cd;
	logic [15:0] cap;
	logic        wv;
	logic [10:0] wa;
	logic [10:0] ra;
	logic [7:0]  wd;
	logic [7:0]  rd;
	logic [18:0] wr_seen;
	int          num_errors;
	int          checked;
	int          cycles;
	int          lanes;
	int          rises;

	aes_link_if link ();
	aes_dev i_aes_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link),
		.i_conv_valid(cv), .o_conv_ready(cr), .i_conv_data(cd),
		.o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wd),
		.o_rd_addr(ra), .i_rd_data(rd));
	aes_host i_aes_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link),
		.i_start(start), .i_word(word), .i_nbits(nbits),
		.o_busy(busy), .o_done(done), .o_rx(rx));
	aes_props i_aes_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.cs_n(link.cs_n), .sclk(link.sclk), .sdo0(link.sdo0),
		.sdo1(link.sdo1), .sdo1_oe(link.sdo1_oe), .ready(link.ready));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			final_report();
		end
	end
	always @(posedge i_clk) if (wv === 1'b1) wr_seen <= {wa, wd};
	always @(negedge link.cs_n) begin
		lanes = 0;
		rises = 0;
	end
	// Wire view of the lanes, sampled on the mode-zero capture edge
	always @(posedge link.sclk) begin
		if (link.cs_n === 1'b0 && lanes < 8) begin
			cap = {cap[13:0], link.sdo1, link.sdo0};
			lanes++;
		end
	end
	always @(posedge link.ready) if (link.cs_n === 1'b0) rises++;

	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [23:0] exp, got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	// Idle gap so the device's synchroniser sees chip select high
	task automatic frame(input logic [23:0] w, input logic [4:0] n);
		int k;
		repeat (10) @(posedge i_clk);
		#1;
		start = 1'b1;
		word = w;
		nbits = n;
		@(posedge i_clk);
		#1;
		start = 1'b0;
		check("frame busy", 24'h000001, 24'(busy));
		for (k = 0; k < 2000 && done !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		check("frame done", 24'h000001, 24'(done));
		check("frame idle", 24'h000000, 24'(busy));
		// Device decodes a few cycles after select rises
		repeat (8) @(posedge i_clk);
		#1;
	endtask
	task automatic push(input logic [15:0] w);
		@(posedge i_clk);
		#1;
		cv = 1'b1;
		cd = w;
		@(posedge i_clk);
		#1;
		cv = 1'b0;
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		frame({aes_pkg::CMD_WR, a, d}, aes_pkg::REG_FRAME_BITS);
	endtask
	task automatic rdreg(input logic [10:0] a, input logic [7:0] e);
		frame({aes_pkg::CMD_RD, a, 8'h00}, aes_pkg::REG_FRAME_BITS);
		check("read address", 24'(a), 24'(ra));
		frame(24'h000000, aes_pkg::REG_FRAME_BITS);
		check("read data", 24'(e), 24'(rx[23:16]));
	endtask
	task automatic conv(input logic [15:0] w);
		push(w);
		frame(24'h000000, aes_pkg::CONV_FRAME_BITS);
		check("conv word", 24'(w), 24'(rx[15:0]));
	endtask

	task automatic t_fifo();
		int i;
		for (i = 0; i < 4; i++) push(16'hC3A0 + 16'(i));
		check("fifo full", 24'h000000, 24'(cr));
		push(16'h5A5A);
		for (i = 0; i < 5; i++) begin
			frame(24'h000000, aes_pkg::CONV_FRAME_BITS);
			check("drain", (i < 4) ? 24'hC3A0 + 24'(i) : 24'h000000,
				24'(rx[15:0]));
		end
	endtask
	task automatic t_regs();
		wr(11'h123, 8'h9C);
		check("write", 24'({11'h123, 8'h9C}), 24'(wr_seen));
		frame({aes_pkg::CMD_WR, 11'h155, 8'h66}, 5'h10);
		check("short write", 24'({11'h123, 8'h9C}), 24'(wr_seen));
		rdreg(aes_pkg::ADDR_IN_CTRL, aes_pkg::IN_CTRL_RST);
		rdreg(11'h2A7, 8'hA5);
	endtask
	task automatic t_prot();
		int p;
		for (p = 1; p < 5; p++) begin
			wr(aes_pkg::ADDR_IN_CTRL, 8'(p % 4));
			conv(16'h8001 ^ 16'(p << 4));
			rdreg(aes_pkg::ADDR_IN_CTRL, 8'(p % 4));
		end
	endtask
	task automatic t_lanes();
		int m;
		for (m = 0; m < 2; m++) begin
			wr(aes_pkg::ADDR_OUT_CTRL, m ? 8'h05 : 8'h04);
			push(16'hB38D);
			frame(24'h000000, aes_pkg::CONV_FRAME_BITS);
			check("lane pairs", 24'h00B38D, 24'(cap));
			check("ready clock", 24'(m), 24'(rises != 0));
		end
		wr(aes_pkg::ADDR_OUT_CTRL, aes_pkg::OUT_CTRL_RST);
		conv(16'h4E71);
	endtask

	initial begin
		i_rst_n = 1'b0;
		start = 1'b0;
		word = 24'h000000;
		nbits = 5'h10;
		cv = 1'b0;
		cd = 16'h0000;
		rd = 8'hA5;
		cap = 16'h0000;
		wr_seen = 19'h00000;
		cycles = 0;
		num_errors = 0;
		checked = 0;
		lanes = 0;
		rises = 0;
		repeat (2) @(posedge i_clk);
		#1;
		i_rst_n = 1'b1;
		t_fifo();
		t_regs();
		t_prot();
		t_lanes();
		final_report();
	end
endmodule // aes_tb_top
